// File: src/sfps_defs.vh
`ifndef SFPS_DEFS_VH
`define SFPS_DEFS_VH

// fixed flash instruction set
`define SFPS_OPC_ARM      8'h06
`define SFPS_OPC_STAT_RD  8'h05
`define SFPS_OPC_STAT_WR  8'h01
`define SFPS_OPC_PP       8'h02
`define SFPS_OPC_SE       8'h20
`define SFPS_OPC_CE       8'hc7

// flash status byte layout
`define SFPS_ST_BUSY_BIT  0
`define SFPS_ST_LATCH_BIT 1
`define SFPS_ST_PROT_HI   6
`define SFPS_ST_PROT_LO   2
`define SFPS_ST_LOCK_BIT  7
`define SFPS_ST_CLEAR     8'h00

// wishbone byte addresses
`define SFPS_REG_CTRL     8'h00
`define SFPS_REG_ADDR     8'h04
`define SFPS_REG_LEN      8'h08
`define SFPS_REG_CLKDIV   8'h0c
`define SFPS_REG_STATUS   8'h10
`define SFPS_REG_PDATA    8'h14

// control register fields
`define SFPS_CTRL_GO_BIT  4
`define SFPS_CTRL_OP_HI   1
`define SFPS_CTRL_OP_LO   0

// software operations
`define SFPS_OP_PROGRAM   2'h0
`define SFPS_OP_SECTOR    2'h1
`define SFPS_OP_CHIP      2'h2
`define SFPS_OP_STATUS    2'h3

// transfer kinds
`define SFPS_K_ARM        3'h0
`define SFPS_K_STAT_RD    3'h1
`define SFPS_K_STAT_WR    3'h2
`define SFPS_K_PP         3'h3
`define SFPS_K_SE         3'h4
`define SFPS_K_CE         3'h5

// clock divider bounds and reset
`define SFPS_DIV_MIN      7'h05
`define SFPS_DIV_MAX      7'h7f
`define SFPS_DIV_RST      7'h05

// frame lengths in bytes
`define SFPS_PAGE_BYTES   9'h100
`define SFPS_HDR_BYTES    9'h004
`define SFPS_ONE_BYTE     9'h001
`define SFPS_TWO_BYTES    9'h002
`define SFPS_LEN_RST      9'h100

`endif

// File: src/sfps_page_ram.v
`timescale 1ns/1ps
module sfps_page_ram (
  input  wire       ref_clk,
  input  wire       wr_en,
  input  wire [7:0] wr_addr,
  input  wire [7:0] wr_data,
  input  wire [7:0] rd_addr,
  output reg  [7:0] rd_data
);

  reg [7:0] mem [0:255];

  // one write port, registered read
  always @(posedge ref_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end

endmodule

// File: src/sfps_seq.v
`timescale 1ns/1ps
`include "sfps_defs.vh"
module sfps_seq (
  input  wire        ref_clk,
  input  wire        rst,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  output reg         spi_clk,
  output reg         spi_mosi,
  input  wire        spi_miso,
  output reg         boot_flash_select_n,
  output reg         spi_cs1_n
);

  // sequencer states
  localparam S_BOOT_ARM  = 4'h0;
  localparam S_BOOT_POLL = 4'h1;
  localparam S_BOOT_CLR  = 4'h2;
  localparam S_IDLE      = 4'h3;
  localparam S_ARM       = 4'h4;
  localparam S_POLL_ARM  = 4'h5;
  localparam S_OP        = 4'h6;
  localparam S_POLL_BUSY = 4'h7;
  localparam S_RD_STAT   = 4'h8;

  // transfer engine states
  localparam E_IDLE  = 3'h0;
  localparam E_SETUP = 3'h1;
  localparam E_LOADW = 3'h2;
  localparam E_LOAD  = 3'h3;
  localparam E_SHIFT = 3'h4;
  localparam E_HOLD  = 3'h5;

  function [31:0] merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0]  sel;
    integer      i;
    begin
      merge = old_v;
      for (i = 0; i < 4; i = i + 1) begin
        if (sel[i]) begin
          merge[i*8 +: 8] = new_v[i*8 +: 8];
        end
      end
    end
  endfunction

  function [7:0] frame_byte;
    input [8:0]  idx;
    input [7:0]  opc;
    input        has_addr;
    input        is_prog;
    input [23:0] addr;
    input [7:0]  ram;
    begin
      if (idx == 9'h000) begin
        frame_byte = opc;
      end else if (has_addr && idx == 9'h001) begin
        frame_byte = addr[23:16];
      end else if (has_addr && idx == 9'h002) begin
        frame_byte = addr[15:8];
      end else if (has_addr && idx == 9'h003) begin
        frame_byte = addr[7:0];
      end else if (is_prog) begin
        frame_byte = ram;
      end else begin
        frame_byte = `SFPS_ST_CLEAR;
      end
    end
  endfunction

  // software-visible registers
  reg  [1:0]  op_sel;
  reg  [23:0] flash_addr;
  reg  [8:0]  xfer_len;
  reg  [6:0]  clk_div;
  reg  [7:0]  page_ptr;
  reg         boot_done;
  reg  [7:0]  last_status;

  // sequencer and engine state
  reg  [3:0]  seq_state;
  reg         launched;
  reg  [2:0]  eng_state;
  reg  [2:0]  kind;
  reg  [7:0]  opc;
  reg  [8:0]  nbytes;
  reg  [8:0]  byte_cnt;
  reg  [2:0]  bit_cnt;
  reg  [7:0]  tx_sh;
  reg  [7:0]  rx_sh;
  reg         eng_done;
  reg  [6:0]  div_cnt;
  reg         tick;
  reg         miso_meta;
  reg         miso_s;

  wire        bus_req;
  wire        wr_stb;
  wire [31:0] rd_val;
  wire [31:0] wmerged;
  wire [7:0]  ram_rd;
  wire [7:0]  ram_raddr;
  wire [8:0]  ram_idx;
  wire [7:0]  cur_byte;
  wire        ram_we;
  wire        go_req;
  wire        has_addr;
  wire        is_prog;
  wire [6:0]  next_div;

  reg  [31:0] rd_mux;

  assign bus_req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_stb    = bus_req && wb_we_i;
  assign wmerged   = merge(rd_val, wb_dat_i, wb_sel_i);
  assign rd_val    = rd_mux;
  assign ram_we    = wr_stb && wb_adr_i == `SFPS_REG_PDATA && wb_sel_i[0];
  assign ram_idx   = byte_cnt - `SFPS_HDR_BYTES;
  assign ram_raddr = ram_idx[7:0];
  assign cur_byte  = frame_byte(byte_cnt, opc, has_addr, is_prog, flash_addr, ram_rd);
  assign go_req    = wr_stb && wb_adr_i == `SFPS_REG_CTRL && wb_sel_i[0] && wb_dat_i[`SFPS_CTRL_GO_BIT];
  assign has_addr  = kind == `SFPS_K_PP || kind == `SFPS_K_SE;
  assign is_prog   = kind == `SFPS_K_PP;
  assign next_div  = wmerged[6:0] < `SFPS_DIV_MIN ? `SFPS_DIV_MIN : wmerged[6:0];

  sfps_page_ram u_ram (
    .ref_clk (ref_clk),
    .wr_en   (ram_we),
    .wr_addr (page_ptr),
    .wr_data (wb_dat_i[7:0]),
    .rd_addr (ram_raddr),
    .rd_data (ram_rd)
  );

  // register read decode
  always @* begin
    rd_mux = 32'h0000_0000;
    if (wb_adr_i == `SFPS_REG_CTRL) begin
      rd_mux[`SFPS_CTRL_OP_HI:`SFPS_CTRL_OP_LO] = op_sel;
    end else if (wb_adr_i == `SFPS_REG_ADDR) begin
      rd_mux[23:0] = flash_addr;
    end else if (wb_adr_i == `SFPS_REG_LEN) begin
      rd_mux[8:0] = xfer_len;
    end else if (wb_adr_i == `SFPS_REG_CLKDIV) begin
      rd_mux[6:0] = clk_div;
    end else if (wb_adr_i == `SFPS_REG_STATUS) begin
      rd_mux[0]    = seq_state != S_IDLE;
      rd_mux[1]    = boot_done;
      rd_mux[15:8] = last_status;
    end else if (wb_adr_i == `SFPS_REG_PDATA) begin
      rd_mux[7:0] = page_ptr;
    end
  end

  // wishbone slave: ack one cycle after request, unmapped reads zero
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wb_ack_o   <= 1'b0;
      wb_dat_o   <= 32'h0000_0000;
      op_sel     <= `SFPS_OP_PROGRAM;
      flash_addr <= 24'h00_0000;
      xfer_len   <= `SFPS_LEN_RST;
      clk_div    <= `SFPS_DIV_RST;
      page_ptr   <= 8'h00;
    end else begin
      wb_ack_o <= bus_req;
      if (bus_req && !wb_we_i) begin
        wb_dat_o <= rd_val;
      end
      if (wr_stb) begin
        if (wb_adr_i == `SFPS_REG_CTRL) begin
          op_sel <= wmerged[`SFPS_CTRL_OP_HI:`SFPS_CTRL_OP_LO];
        end else if (wb_adr_i == `SFPS_REG_ADDR) begin
          flash_addr <= wmerged[23:0];
        end else if (wb_adr_i == `SFPS_REG_LEN) begin
          // one page at most per program frame
          if (wmerged[8:0] > `SFPS_PAGE_BYTES || wmerged[8:0] == 9'h000) begin
            xfer_len <= `SFPS_PAGE_BYTES;
          end else begin
            xfer_len <= wmerged[8:0];
          end
          page_ptr <= 8'h00;
        end else if (wb_adr_i == `SFPS_REG_CLKDIV) begin
          clk_div <= next_div;
        end else if (wb_adr_i == `SFPS_REG_PDATA && wb_sel_i[0]) begin
          page_ptr <= page_ptr + 8'h01;
        end
      end
    end
  end

  // divider: half serial period is clk_div ref cycles
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      div_cnt <= 7'h00;
      tick    <= 1'b0;
    end else if (div_cnt >= clk_div - 7'h01) begin
      div_cnt <= 7'h00;
      tick    <= 1'b1;
    end else begin
      div_cnt <= div_cnt + 7'h01;
      tick    <= 1'b0;
    end
  end

  // miso synchroniser
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      miso_meta <= 1'b0;
      miso_s    <= 1'b0;
    end else begin
      miso_meta <= spi_miso;
      miso_s    <= miso_meta;
    end
  end

  // frame engine, mode 0 single lane on select zero only
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      eng_state           <= E_IDLE;
      spi_clk             <= 1'b0;
      spi_mosi            <= 1'b0;
      boot_flash_select_n <= 1'b1;
      spi_cs1_n           <= 1'b1;
      byte_cnt            <= 9'h000;
      bit_cnt             <= 3'h0;
      tx_sh               <= 8'h00;
      rx_sh               <= 8'h00;
      eng_done            <= 1'b0;
      last_status         <= 8'h00;
    end else begin
      eng_done <= 1'b0;
      case (eng_state)
        E_IDLE: begin
          if (launched && !eng_done && seq_state != S_IDLE) begin
            eng_state <= E_SETUP;
          end
        end
        E_SETUP: begin
          boot_flash_select_n <= 1'b0;
          byte_cnt            <= 9'h000;
          if (tick && !boot_flash_select_n) begin
            eng_state <= E_LOADW;
          end
        end
        E_LOADW: begin
          eng_state <= E_LOAD;
        end
        E_LOAD: begin
          tx_sh     <= cur_byte;
          spi_mosi  <= cur_byte[7];
          bit_cnt   <= 3'h0;
          eng_state <= E_SHIFT;
        end
        E_SHIFT: begin
          if (tick && !spi_clk) begin
            spi_clk <= 1'b1;
            rx_sh   <= {rx_sh[6:0], miso_s};
          end else if (tick) begin
            spi_clk <= 1'b0;
            if (bit_cnt == 3'h7) begin
              byte_cnt <= byte_cnt + 9'h001;
              if (byte_cnt + 9'h001 == nbytes) begin
                eng_state <= E_HOLD;
                // a single status byte is taken
                if (kind == `SFPS_K_STAT_RD) begin
                  last_status <= rx_sh;
                end
              end else begin
                eng_state <= E_LOADW;
              end
            end else begin
              bit_cnt  <= bit_cnt + 3'h1;
              tx_sh    <= {tx_sh[6:0], 1'b0};
              spi_mosi <= tx_sh[6];
            end
          end
        end
        E_HOLD: begin
          boot_flash_select_n <= 1'b1;
          if (tick && boot_flash_select_n) begin
            eng_state <= E_IDLE;
            eng_done  <= 1'b1;
          end
        end
        default: begin
          eng_state <= E_IDLE;
        end
      endcase
    end
  end

  // sequencer: boot unlock, then arm/poll/operate/poll per request, a single status read for a status request
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      seq_state <= S_BOOT_ARM;
      launched  <= 1'b0;
      boot_done <= 1'b0;
      kind      <= `SFPS_K_ARM;
      opc       <= `SFPS_OPC_ARM;
      nbytes    <= `SFPS_ONE_BYTE;
    end else begin
      if (!launched && seq_state != S_IDLE) begin
        launched <= 1'b1;
        case (seq_state)
          S_BOOT_ARM, S_ARM: begin
            kind   <= `SFPS_K_ARM;
            opc    <= `SFPS_OPC_ARM;
            nbytes <= `SFPS_ONE_BYTE;
          end
          S_BOOT_POLL, S_POLL_ARM, S_POLL_BUSY, S_RD_STAT: begin
            kind   <= `SFPS_K_STAT_RD;
            opc    <= `SFPS_OPC_STAT_RD;
            nbytes <= `SFPS_TWO_BYTES;
          end
          S_BOOT_CLR: begin
            kind   <= `SFPS_K_STAT_WR;
            opc    <= `SFPS_OPC_STAT_WR;
            nbytes <= `SFPS_TWO_BYTES;
          end
          default: begin
            if (op_sel == `SFPS_OP_PROGRAM) begin
              kind   <= `SFPS_K_PP;
              opc    <= `SFPS_OPC_PP;
              nbytes <= `SFPS_HDR_BYTES + xfer_len;
            end else if (op_sel == `SFPS_OP_SECTOR) begin
              kind   <= `SFPS_K_SE;
              opc    <= `SFPS_OPC_SE;
              nbytes <= `SFPS_HDR_BYTES;
            end else begin
              kind   <= `SFPS_K_CE;
              opc    <= `SFPS_OPC_CE;
              nbytes <= `SFPS_ONE_BYTE;
            end
          end
        endcase
      end else if (eng_done) begin
        launched <= 1'b0;
        case (seq_state)
          S_BOOT_ARM: begin
            seq_state <= S_BOOT_POLL;
          end
          S_BOOT_POLL: begin
            if (last_status[`SFPS_ST_LATCH_BIT]) begin
              seq_state <= S_BOOT_CLR;
            end
          end
          S_BOOT_CLR: begin
            boot_done <= 1'b1;
            seq_state <= S_POLL_BUSY;
          end
          S_ARM: begin
            seq_state <= S_POLL_ARM;
          end
          S_POLL_ARM: begin
            if (last_status[`SFPS_ST_LATCH_BIT]) begin
              seq_state <= S_OP;
            end
          end
          S_OP: begin
            seq_state <= S_POLL_BUSY;
          end
          S_POLL_BUSY: begin
            if (!last_status[`SFPS_ST_BUSY_BIT]) begin
              seq_state <= S_IDLE;
            end
          end
          default: begin
            seq_state <= S_IDLE;
          end
        endcase
      end else if (seq_state == S_IDLE && go_req) begin
        if (wb_dat_i[`SFPS_CTRL_OP_HI:`SFPS_CTRL_OP_LO] == `SFPS_OP_STATUS) begin
          seq_state <= S_RD_STAT;
        end else begin
          seq_state <= S_ARM;
        end
      end
    end
  end

endmodule

// File: verif/sfps_seq_monitor.sv
`timescale 1ns/1ps
module sfps_seq_monitor (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic spi_clk,
  input wire logic spi_mosi,
  input wire logic boot_flash_select_n,
  input wire logic spi_cs1_n
);
  logic [2:0] bits;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  always @(posedge ref_clk or posedge rst) begin
    if (rst)
      bits <= 3'h0;
    else if (boot_flash_select_n)
      bits <= 3'h0;
    else if ($rose(spi_clk))
      bits <= bits + 3'h1;
  end
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
  a_ack_next_cycle: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
  a_ack_has_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
  a_second_select_idle: assert property (spi_cs1_n) else $error("second select used");
  a_clock_idle_low: assert property (boot_flash_select_n |-> !spi_clk) else $error("clock not idle low");
  a_clock_high_time: assert property ($rose(spi_clk) |-> spi_clk [*5]) else $error("clock high too short");
  a_clock_low_time: assert property ($fell(spi_clk) |-> !spi_clk [*5]) else $error("clock low too short");
  a_select_setup: assert property ($fell(boot_flash_select_n) |-> !spi_clk [*5]) else $error("no select setup");
  a_mosi_on_low: assert property ($changed(spi_mosi) |-> !spi_clk) else $error("data moved on high clock");
  a_whole_bytes: assert property ($rose(boot_flash_select_n) |-> bits == 3'h0) else $error("partial byte");
endmodule
bind sfps_seq sfps_seq_monitor u_mon (.ref_clk(ref_clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .spi_clk(spi_clk), .spi_mosi(spi_mosi), .boot_flash_select_n(boot_flash_select_n),
  .spi_cs1_n(spi_cs1_n));

// File: verif/sfps_flash_model.sv
`timescale 1ns/1ps
module sfps_flash_model (
  input  wire logic       sck,
  input  wire logic       cs_n,
  input  wire logic       mosi,
  output logic            miso,
  input  wire logic [3:0] lag
);
  logic [7:0] prot = 8'h9c;  // powers up protected
  logic       latch = 1'b0;
  logic       bsy = 1'b0;
  logic [7:0] sh;
  int         cnt;
  int         wait_n = 0;
  int         bad = 0;
  int         hi_ns;
  realtime    t_r;
  logic [7:0] ops[$];
  logic [7:0] fr[$];
  logic [7:0] last[$];
  wire  [7:0] st = {prot[7:2], latch && wait_n == 0, bsy && wait_n != 0};
  initial miso = 1'b0;
  always @(negedge cs_n) begin
    cnt = 0;
    fr.delete();
  end
  always @(posedge sck) begin
    sh = {sh[6:0], mosi};
    cnt++;
    t_r = $realtime;
    if (cnt % 8 == 0) fr.push_back(sh);
  end
  always @(negedge sck) begin
    hi_ns = int'($realtime - t_r);
    miso <= (fr.size() > 0 && fr[0] == 8'h05 && cnt < 16) ? st[15 - cnt] : ~miso;
  end
  always @(posedge cs_n) begin
    miso <= ~miso;
    if (fr.size() > 0) begin
      ops.push_back(fr[0]);
      if (cnt % 8 != 0 || (fr[0] != 8'h05 && bsy && wait_n != 0)) bad++;
      case (fr[0])
        8'h06: begin
          latch = 1'b1;
          bsy = 1'b0;
          wait_n = lag;
        end
        8'h05: begin
          if (cnt != 16) bad++;
          if (wait_n > 0) wait_n--;
        end
        8'h01, 8'h02, 8'h20, 8'hc7: begin
          if (!st[1] || (fr[0] == 8'h01 && cnt != 16)) bad++;
          if (fr[0] == 8'h01) prot = fr[1];  // one byte, no extra byte
          last = fr;
          latch = 1'b0;
          bsy = 1'b1;
          wait_n = lag;
        end
        default: bad++;
      endcase
    end
  end
endmodule

// File: verif/spi_flash_protect_sequencer_test.sv
`timescale 1ns/1ps
module spi_flash_protect_sequencer_test;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0;
  logic [3:0]  wb_sel_i = 4'hf;
  logic [3:0]  lanes = 4'hf;
  logic [3:0]  lag = 4'h2;
  wire  [31:0] wb_dat_o;
  wire         wb_ack_o;
  wire         sck;
  wire         mosi;
  wire         miso;
  wire         sel_n;
  int          fails = 0;
  int          checked = 0;
  logic [7:0]  ex[$];
  sfps_seq uut (.ref_clk(ref_clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .spi_clk(sck), .spi_mosi(mosi), .spi_miso(miso), .boot_flash_select_n(sel_n), .spi_cs1_n());
  sfps_flash_model flash (.sck(sck), .cs_n(sel_n), .mosi(mosi), .miso(miso), .lag(lag));
  initial forever #25 ref_clk = ~ref_clk;
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= lanes;
    do begin
      @(posedge ref_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    q = wb_dat_o;
    if (wb_ack_o !== 1'b1) begin
      fails++;
      end_sim();
    end
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic idle();
    int n;
    logic [31:0] q;
    n = 0;
    do begin
      wb(1'b0, 8'h10, 32'h0, q);
      n++;
    end while (q[1:0] !== 2'b10 && n < 3000);
    if (q[1:0] !== 2'b10) begin
      fails++;
      end_sim();
    end
  endtask
  task automatic polls();
    repeat (lag + 1) ex.push_back(8'h05);
  endtask
  task automatic arm();
    ex.push_back(8'h06);
    polls();
  endtask
  task automatic seq_chk(input string w);
    chk(w, ex.size(), flash.ops.size());
    foreach (ex[i]) chk(w, ex[i], flash.ops[i]);
    ex.delete();
    flash.ops.delete();
  endtask
  task automatic boot_unlock();
    idle();
    arm();
    ex.push_back(8'h01);
    polls();
    seq_chk("boot frames");
    chk("status written", 32'h0, flash.prot);
  endtask
  task automatic program_page();
    logic [7:0] pf[6] = '{8'h02, 8'h01, 8'h23, 8'h45, 8'ha5, 8'h3c};
    logic [31:0] q;
    lag <= 4'h0;
    wr(8'h08, 32'h2);
    lanes = 4'he;
    wr(8'h14, 32'h77);
    lanes = 4'hf;
    wb(1'b0, 8'h14, 32'h0, q);
    chk("page write without lane 0", 32'h0, q);
    wr(8'h14, 32'ha5);
    wr(8'h14, 32'h3c);
    wb(1'b0, 8'h14, 32'h0, q);
    chk("page pointer", 32'h2, q);
    lanes = 4'hc;
    wr(8'h04, 32'h01ffff);
    lanes = 4'h3;
    wr(8'h04, 32'hff2345);
    lanes = 4'hf;
    wb(1'b0, 8'h04, 32'h0, q);
    chk("address lanes", 32'h012345, q);
    wr(8'h00, 32'h10);
    idle();
    arm();
    ex.push_back(8'h02);
    polls();
    seq_chk("program frames");
    foreach (pf[i]) chk("program bytes", pf[i], flash.last[i]);
  endtask
  task automatic erase_both();
    logic [31:0] q;
    logic [7:0] opc[2] = '{8'h20, 8'hc7};
    lag <= 4'h3;
    wr(8'h0c, 32'h3);
    wb(1'b0, 8'h0c, 32'h0, q);
    chk("divider floor", 32'h5, q);
    wb(1'b0, 8'h1c, 32'h0, q);
    chk("unmapped read", 32'h0, q);
    wr(8'h08, 32'h1ff);
    wb(1'b0, 8'h08, 32'h0, q);
    chk("length clamp", 32'h100, q);
    wr(8'h08, 32'h0);
    wb(1'b0, 8'h08, 32'h0, q);
    chk("length zero clamp", 32'h100, q);
    wr(8'h0c, 32'h7);
    foreach (opc[i]) begin
      wr(8'h00, 32'h11 + i);
      idle();
      arm();
      ex.push_back(opc[i]);
      polls();
      seq_chk("erase frames");
      chk("erase length", 4 - 3 * i, flash.last.size());
      chk("half period ns", 350, flash.hi_ns);
    end
  endtask
  task automatic status_read();
    logic [31:0] q;
    flash.prot = 8'hd4;
    wr(8'h00, 32'h13);
    idle();
    ex.push_back(8'h05);
    seq_chk("status frames");
    wb(1'b0, 8'h10, 32'h0, q);
    chk("status byte", 32'hd4, q[15:8]);
    chk("flash faults", 0, flash.bad);
  endtask
  initial begin
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    boot_unlock();
    program_page();
    erase_both();
    status_read();
    end_sim();
  end
endmodule
